/* logic/cmpdc_top.sv */
// comparator digital control: registers, filter, sync, edge flags, AHB-Lite slave
//
// Implementation choices: the register addresses and the AHB-Lite register port.

// How it works
// - filter blocks reversal for 20 ns
// - control a bit 3 enables glitch filter
// - control a bit 7 enables comparator
// - result bit 6, inverted by polarity bit
// - pin drive enable routes result to pin
// - speed bit resets one, others zero
// - control a bit 1 enables hysteresis
// - sync mode updates on timer falling edge
// - no sync mode passes result straight
// - rising edge enable sets interrupt flag
// - falling edge enable sets interrupt flag
// - two-bit positive channel select codes
// - negative select picks first/second pin
// - unimplemented bits ignore writes, read zero
// - mirror holds both results, bits 1:0
// - port read gives zero for analog pins
// - software clears flag; edge wins clear
// - internal result sampled each instruction cycle
// - sync sampling uses prescaled timer clock
module cmpdc_top (
   // clock and reset
   input  wire logic                      core_clk_in,
   input  wire logic                      rstn_in,
   // ahb-lite slave
   input  wire logic                      hsel_in,
   input  wire logic [31:0]               haddr_in,
   input  wire logic [1:0]                htrans_in,
   input  wire logic                      hwrite_in,
   input  wire logic [2:0]                hsize_in,
   input  wire logic [31:0]               hwdata_in,
   input  wire logic                      hready_in,
   output logic      [31:0]               hrdata_out,
   output logic                           hreadyout_out,
   output logic                           hresp_out,
   // analog core
   input  wire logic [1:0]                raw_decision_in,
   output cmpdc_pkg::cmpdc_analog_s [1:0] analog_ctrl_out,
   // timer 1 prescaled clock, sampled
   input  wire logic                      timer_clk_in,
   output logic      [1:0]                timer_result_out,
   // pins
   output logic      [1:0]                pin_result_out,
   output logic      [1:0]                pin_override_out,
   input  wire logic [cmpdc_pkg::PORT_W-1:0] port_level_in,
   input  wire logic [cmpdc_pkg::PORT_W-1:0] analog_sel_in,
   // interrupt flags to the interrupt controller
   output logic      [1:0]                cmp_irq_flag_out
);

   typedef struct packed {
      cmpdc_pkg::cmpdc_chan_s [1:0] ch;
      logic                         tclk_prev;
      logic [1:0]                   icyc;
      logic                         dp_act;
      logic                         dp_wr;
      logic [7:0]                   dp_addr;
      logic [31:0]                  rdata;
      cmpdc_pkg::cmpdc_analog_s [1:0] actl;
      logic [1:0]                   tres;
      logic [1:0]                   pres;
      logic [1:0]                   poe;
   } cmpdc_state_s;

   cmpdc_state_s st_r;
   cmpdc_state_s st_nxt;

   default clocking cb_core @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);

   // polarity applied to the raw decision
   function automatic logic polar(input logic raw, input logic [7:0] ca);
      return raw ^ ca[cmpdc_pkg::BIT_INVERT];
   endfunction

   // control a write keeps the read-only result bit
   function automatic logic [7:0] merge_a(input logic [7:0] old, input logic [7:0] wd);
      return (old & ~cmpdc_pkg::CTRL_A_WMASK) | (wd & cmpdc_pkg::CTRL_A_WMASK);
   endfunction

   function automatic cmpdc_pkg::cmpdc_chan_s chan_reset();
      cmpdc_pkg::cmpdc_chan_s c;
      c = '0;
      c.ctrl_a = cmpdc_pkg::CTRL_A_RESET;
      c.ctrl_b = cmpdc_pkg::CTRL_B_RESET;
      return c;
   endfunction

   function automatic logic [31:0] read_word(input cmpdc_state_s s, input logic [7:0] a,
                                             input logic [5:0] port);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (a)
         cmpdc_pkg::OFF_C1_CTRL_A: w[7:0] = s.ch[0].ctrl_a;
         cmpdc_pkg::OFF_C1_CTRL_B: w[7:0] = s.ch[0].ctrl_b;
         cmpdc_pkg::OFF_C2_CTRL_A: w[7:0] = s.ch[1].ctrl_a;
         cmpdc_pkg::OFF_C2_CTRL_B: w[7:0] = s.ch[1].ctrl_b;
         cmpdc_pkg::OFF_MIRROR:    w[1:0] = {s.ch[1].latched, s.ch[0].latched};
         cmpdc_pkg::OFF_IRQ_FLAGS: w[1:0] = {s.ch[1].irq, s.ch[0].irq};
         cmpdc_pkg::OFF_PORT_DATA: w[5:0] = port;
         default:                  w = 32'h0000_0000;
      endcase
      return w;
   endfunction

   logic timer_fall;
   assign timer_fall = st_r.tclk_prev & ~timer_clk_in;

   always_comb begin
      logic       pol;
      logic       outv;
      logic       rise;
      logic       fall;
      logic       wr;
      logic [7:0] wb;
      pol   = 1'b0;
      outv  = 1'b0;
      rise  = 1'b0;
      fall  = 1'b0;
      wr    = 1'b0;
      wb    = 8'h00;
      st_nxt = st_r;
      st_nxt.tclk_prev = timer_clk_in;
      st_nxt.icyc = st_r.icyc + 2'h1;

      // bus address phase capture; slave always zero wait state
      st_nxt.dp_act = hsel_in & hready_in & htrans_in[1];
      if (hsel_in && hready_in && htrans_in[1]) begin
         st_nxt.dp_wr   = hwrite_in;
         st_nxt.dp_addr = haddr_in[7:0];
      end
      wr = st_r.dp_act & st_r.dp_wr;
      wb = hwdata_in[7:0];

      for (int i = 0; i < 2; i++) begin
         pol = polar(raw_decision_in[i], st_r.ch[i].ctrl_a);
         // filter: accept change only when hold counter expired
         if (st_r.ch[i].ctrl_a[cmpdc_pkg::BIT_FILTER]) begin
            if (st_r.ch[i].fcnt != 2'h0) begin
               st_nxt.ch[i].fcnt = st_r.ch[i].fcnt - 2'h1;
            end else if (pol != st_r.ch[i].filt) begin
               st_nxt.ch[i].filt = pol;
               st_nxt.ch[i].fcnt = cmpdc_pkg::FILT_CNT_MAX;
            end
         end else begin
            st_nxt.ch[i].filt = pol;
            st_nxt.ch[i].fcnt = 2'h0;
         end
         outv = st_nxt.ch[i].filt;
         // external path: latched on timer fall or passed through
         if (st_r.ch[i].ctrl_a[cmpdc_pkg::BIT_SYNC]) begin
            if (timer_fall) begin
               st_nxt.ch[i].synced = outv;
            end
         end else begin
            st_nxt.ch[i].synced = outv;
         end
         st_nxt.tres[i] = st_nxt.ch[i].synced;
         st_nxt.pres[i] = st_nxt.ch[i].synced;
         st_nxt.poe[i]  = st_r.ch[i].ctrl_a[cmpdc_pkg::BIT_PIN_OE];
         // internal result latched once per instruction cycle
         if (st_r.icyc == cmpdc_pkg::INSTR_LAST) begin
            st_nxt.ch[i].latched = outv;
         end
         st_nxt.ch[i].ctrl_a[cmpdc_pkg::BIT_RESULT] = st_nxt.ch[i].latched;
         // one cycle behind latched, so the detectors see each change once
         st_nxt.ch[i].prev = st_r.ch[i].latched;
         rise = ~st_r.ch[i].prev & st_r.ch[i].latched;
         fall = st_r.ch[i].prev & ~st_r.ch[i].latched;
         // software clear first, edge set wins
         if (wr && st_r.dp_addr == cmpdc_pkg::OFF_IRQ_FLAGS && wb[i]) begin
            st_nxt.ch[i].irq = 1'b0;
         end
         if ((rise && st_r.ch[i].ctrl_b[cmpdc_pkg::BIT_RISE_IE]) ||
             (fall && st_r.ch[i].ctrl_b[cmpdc_pkg::BIT_FALL_IE])) begin
            st_nxt.ch[i].irq = 1'b1;
         end
         st_nxt.actl[i].enable = st_r.ch[i].ctrl_a[cmpdc_pkg::BIT_ENABLE];
         st_nxt.actl[i].speed  = st_r.ch[i].ctrl_a[cmpdc_pkg::BIT_SPEED];
         st_nxt.actl[i].hyst   = st_r.ch[i].ctrl_a[cmpdc_pkg::BIT_HYST];
         st_nxt.actl[i].pch    = st_r.ch[i].ctrl_b[cmpdc_pkg::BIT_PCH_LO +: 2];
         st_nxt.actl[i].nch    = st_r.ch[i].ctrl_b[cmpdc_pkg::BIT_NCH];
      end

      // register writes; result bit and reserved bits kept out by masks
      if (wr) begin
         case (st_r.dp_addr)
            cmpdc_pkg::OFF_C1_CTRL_A: st_nxt.ch[0].ctrl_a = merge_a(st_nxt.ch[0].ctrl_a, wb);
            cmpdc_pkg::OFF_C2_CTRL_A: st_nxt.ch[1].ctrl_a = merge_a(st_nxt.ch[1].ctrl_a, wb);
            cmpdc_pkg::OFF_C1_CTRL_B: st_nxt.ch[0].ctrl_b = wb & cmpdc_pkg::CTRL_B_WMASK;
            cmpdc_pkg::OFF_C2_CTRL_B: st_nxt.ch[1].ctrl_b = wb & cmpdc_pkg::CTRL_B_WMASK;
            default: ;
         endcase
      end

      // read data prepared for the next data phase; analog pins read zero
      st_nxt.rdata = read_word(st_nxt, haddr_in[7:0], port_level_in & ~analog_sel_in);
   end

   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_r       <= '0;
         st_r.ch[0] <= chan_reset();
         st_r.ch[1] <= chan_reset();
         st_r.actl[0].speed <= 1'b1;
         st_r.actl[1].speed <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign hrdata_out       = st_r.rdata;
   assign hreadyout_out    = 1'b1;
   assign hresp_out        = 1'b0;
   assign analog_ctrl_out  = st_r.actl;
   assign timer_result_out = st_r.tres;
   assign pin_result_out   = st_r.pres;
   assign pin_override_out = st_r.poe;
   assign cmp_irq_flag_out = {st_r.ch[1].irq, st_r.ch[0].irq};

   // assertions
   a_filter_holds: assert property (
      (st_r.ch[0].ctrl_a[3] && $changed(st_r.ch[0].filt) && $stable(st_r.ch[0].ctrl_a[3]))
      |=> $stable(st_r.ch[0].filt))
      else $error("filter reversed inside hold time");

   a_filter_zero_lat: assert property (
      (st_r.ch[0].ctrl_a[3] && st_r.ch[0].fcnt == 2'h0
       && (raw_decision_in[0] ^ st_r.ch[0].ctrl_a[4]) != st_r.ch[0].filt)
      |=> $changed(st_r.ch[0].filt) && st_r.ch[0].fcnt == cmpdc_pkg::FILT_CNT_MAX)
      else $error("filter did not pass change at once");

   a_filter_count: assert property (
      (st_r.ch[0].ctrl_a[3] && st_r.ch[0].fcnt != 2'h0)
      |=> st_r.ch[0].fcnt == $past(st_r.ch[0].fcnt) - 2'h1)
      else $error("hold counter did not count down");

   a_filter_bypass: assert property (
      !st_r.ch[0].ctrl_a[3]
      |=> st_r.ch[0].filt == ($past(raw_decision_in[0]) ^ $past(st_r.ch[0].ctrl_a[4])))
      else $error("bypass does not follow input");

   a_bypass_count: assert property (
      !st_r.ch[0].ctrl_a[3] |=> st_r.ch[0].fcnt == 2'h0)
      else $error("hold counter runs with filter off");

   a_enable_out: assert property (
      ##1 analog_ctrl_out[0].enable == $past(st_r.ch[0].ctrl_a[7], 1))
      else $error("enable not forwarded");

   a_enable_second: assert property (
      ##1 analog_ctrl_out[1].enable == $past(st_r.ch[1].ctrl_a[7]))
      else $error("second enable not forwarded");

   a_speed_out: assert property (
      ##1 analog_ctrl_out[0].speed == $past(st_r.ch[0].ctrl_a[2]))
      else $error("speed select not forwarded");

   a_hyst_out: assert property (
      ##1 analog_ctrl_out[0].hyst == $past(st_r.ch[0].ctrl_a[1]))
      else $error("hysteresis not forwarded");

   a_pch_out: assert property (
      ##1 analog_ctrl_out[0].pch == $past(st_r.ch[0].ctrl_b[5:4]))
      else $error("positive select not forwarded");

   a_nch_out: assert property (
      ##1 analog_ctrl_out[0].nch == $past(st_r.ch[0].ctrl_b[0]))
      else $error("negative select not forwarded");

   a_pin_drive: assert property (
      ##1 pin_override_out[1] == $past(st_r.ch[1].ctrl_a[5]))
      else $error("pin override wrong");

   a_pin_drive_first: assert property (
      ##1 pin_override_out[0] == $past(st_r.ch[0].ctrl_a[5]))
      else $error("first pin override wrong");

   a_result_first: assert property (
      (st_r.icyc == cmpdc_pkg::INSTR_LAST && !st_r.ch[0].ctrl_a[3])
      |=> st_r.ch[0].latched == ($past(raw_decision_in[0]) ^ $past(st_r.ch[0].ctrl_a[4])))
      else $error("first result polarity wrong");

   a_result_second: assert property (
      (st_r.icyc == cmpdc_pkg::INSTR_LAST && !st_r.ch[1].ctrl_a[3])
      |=> st_r.ch[1].latched == ($past(raw_decision_in[1]) ^ $past(st_r.ch[1].ctrl_a[4])))
      else $error("second result polarity wrong");

   a_latch_hold: assert property (
      st_r.icyc != cmpdc_pkg::INSTR_LAST |=> $stable(st_r.ch[0].latched))
      else $error("result latched off the instruction cycle");

   a_nosync_pass: assert property (
      !st_r.ch[0].ctrl_a[0]
      |=> pin_result_out[0] == st_r.ch[0].filt && timer_result_out[0] == st_r.ch[0].filt)
      else $error("first result not passed through");

   a_nosync_second: assert property (
      !st_r.ch[1].ctrl_a[0]
      |=> pin_result_out[1] == st_r.ch[1].filt && timer_result_out[1] == st_r.ch[1].filt)
      else $error("second result not passed through");

   a_sync_hold: assert property (
      (st_r.ch[0].ctrl_a[0] && !timer_fall) |=> $stable(st_r.ch[0].synced))
      else $error("sync output moved without timer fall");

   a_sync_take: assert property (
      (st_r.ch[0].ctrl_a[0] && timer_fall)
      |=> pin_result_out[0] == st_r.ch[0].filt && timer_result_out[0] == st_r.ch[0].filt)
      else $error("sync output missed timer fall");

   a_rise_flag: assert property (
      (st_r.ch[0].ctrl_b[7] && !st_r.ch[0].prev && st_r.ch[0].latched) |=> st_r.ch[0].irq)
      else $error("rising edge did not set flag");

   a_fall_flag: assert property (
      (st_r.ch[0].ctrl_b[6] && st_r.ch[0].prev && !st_r.ch[0].latched) |=> st_r.ch[0].irq)
      else $error("falling edge did not set flag");

   a_no_edge_flag: assert property (
      (st_r.ch[0].ctrl_b[7:6] == 2'h0 && !st_r.ch[0].irq) |=> !st_r.ch[0].irq)
      else $error("flag set with both edges off");

   a_flag_clear: assert property (
      (st_r.dp_act && st_r.dp_wr && st_r.dp_addr == cmpdc_pkg::OFF_IRQ_FLAGS
       && hwdata_in[0] && st_r.ch[0].ctrl_b[7:6] == 2'h0) |=> !st_r.ch[0].irq)
      else $error("flag not cleared by write");

   a_flag_sticky: assert property (
      (st_r.ch[0].irq && !(st_r.dp_act && st_r.dp_wr)) |=> st_r.ch[0].irq)
      else $error("flag dropped without a write");

   a_reserved_zero: assert property (
      st_r.ch[0].ctrl_b[3:1] == 3'h0 && st_r.ch[1].ctrl_b[3:1] == 3'h0)
      else $error("reserved bits set");

   a_ctrlb_write: assert property (
      (st_r.dp_act && st_r.dp_wr && st_r.dp_addr == cmpdc_pkg::OFF_C1_CTRL_B)
      |=> st_r.ch[0].ctrl_b == ($past(hwdata_in[7:0]) & 8'hF1))
      else $error("control b write wrong");

   a_mirror_read: assert property (
      (hsel_in && hready_in && htrans_in[1] && haddr_in[7:0] == cmpdc_pkg::OFF_MIRROR)
      |=> hrdata_out[1:0] == {st_r.ch[1].latched, st_r.ch[0].latched})
      else $error("mirror read wrong");

   a_mirror_high: assert property (
      (hsel_in && hready_in && htrans_in[1] && haddr_in[7:0] == cmpdc_pkg::OFF_MIRROR)
      |=> hrdata_out[7:2] == 6'h00)
      else $error("mirror upper bits not zero");

   a_port_read: assert property (
      (hsel_in && hready_in && htrans_in[1] && haddr_in[7:0] == cmpdc_pkg::OFF_PORT_DATA)
      |=> (hrdata_out[5:0] & $past(analog_sel_in)) == 6'h00)
      else $error("analog pin read not zero");
endmodule

/* logic/cmpdc_pkg.sv */
// shared constants and types for the comparator digital control block
package cmpdc_pkg;
   // register byte offsets on the AHB-Lite slave
   localparam logic [7:0] OFF_C1_CTRL_A = 8'h00;
   localparam logic [7:0] OFF_C1_CTRL_B = 8'h04;
   localparam logic [7:0] OFF_C2_CTRL_A = 8'h08;
   localparam logic [7:0] OFF_C2_CTRL_B = 8'h0C;
   localparam logic [7:0] OFF_MIRROR    = 8'h10;
   localparam logic [7:0] OFF_IRQ_FLAGS = 8'h14;
   localparam logic [7:0] OFF_PORT_DATA = 8'h18;
   // control a field positions
   localparam int BIT_ENABLE  = 7;
   localparam int BIT_RESULT  = 6;
   localparam int BIT_PIN_OE  = 5;
   localparam int BIT_INVERT  = 4;
   localparam int BIT_FILTER  = 3;
   localparam int BIT_SPEED   = 2;
   localparam int BIT_HYST    = 1;
   localparam int BIT_SYNC    = 0;
   // control b field positions
   localparam int BIT_RISE_IE = 7;
   localparam int BIT_FALL_IE = 6;
   localparam int BIT_PCH_LO  = 4;
   localparam int BIT_NCH     = 0;
   // writable masks and reset values
   localparam logic [7:0] CTRL_A_WMASK = 8'hBF;
   localparam logic [7:0] CTRL_B_WMASK = 8'hF1;
   localparam logic [7:0] CTRL_A_RESET = 8'h04;
   localparam logic [7:0] CTRL_B_RESET = 8'h00;
   // positive channel codes
   localparam logic [1:0] PCH_PIN   = 2'h0;
   localparam logic [1:0] PCH_DAC   = 2'h1;
   localparam logic [1:0] PCH_FVR   = 2'h2;
   localparam logic [1:0] PCH_GND   = 2'h3;
   // glitch hold time
   localparam int CLK_PERIOD_NS  = 10;
   localparam int FILT_HOLD_NS   = 20;
   localparam int FILT_CYCLES    = (FILT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // the change edge itself is the first blocked cycle
   localparam logic [1:0] FILT_CNT_MAX = 2'(FILT_CYCLES - 1);
   // instruction cycle = 4 system clocks
   localparam logic [1:0] INSTR_LAST = 2'h3;
   localparam int PORT_W = 6;

   // per-comparator analog control
   typedef struct packed {
      logic       enable;
      logic       speed;
      logic       hyst;
      logic [1:0] pch;
      logic       nch;
   } cmpdc_analog_s;

   // per-comparator state
   typedef struct packed {
      logic [7:0] ctrl_a;
      logic [7:0] ctrl_b;
      logic       filt;
      logic [1:0] fcnt;
      logic       synced;
      logic       latched;
      logic       prev;
      logic       irq;
   } cmpdc_chan_s;
endpackage

/* bench/cmpdc_partner.sv */
// stand-in for the analog comparator core and the prescaled timer clock
module cmpdc_partner (
   // clock
   input  wire logic                           core_clk_in,
   // analog side
   input  wire cmpdc_pkg::cmpdc_analog_s [1:0] ctrl_in,
   input  wire logic [1:0][2:0][7:0]           vpos_in,
   input  wire logic [1:0][1:0][7:0]           vneg_in,
   output logic      [1:0]                     raw_out,
   // timer clock
   input  wire logic                           tclk_run_in,
   output logic                                tclk_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] div_r = 2'h0;
   initial tclk_out = 1'b1;
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         raw_out[i] = ctrl_in[i].enable && ctrl_in[i].pch != cmpdc_pkg::PCH_GND
            && vpos_in[i][ctrl_in[i].pch] > vneg_in[i][ctrl_in[i].nch];
      end
   end
   // parked high when idle, so no stray falling edge reaches the sync path
   always @(posedge core_clk_in) begin
      div_r <= tclk_run_in ? div_r + 2'h1 : 2'h0;
      if (!tclk_run_in)
         tclk_out <= 1'b1;
      else if (div_r == 2'h3)
         tclk_out <= ~tclk_out;
   end
endmodule

/* bench/cmpdc_top_tb.sv */
// self-checking bench for the comparator digital control block
module cmpdc_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0, rstn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
   logic        rd_ph = 1'b0, trun = 1'b0, hrdy, hresp, tclk;
   logic [1:0]  htrans = 2'h0, raw, tres, pres, povr, irq;
   logic [2:0]  hsize = 3'h2;
   logic [5:0]  plvl = 6'h00, asel = 6'h00;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
   logic [1:0][2:0][7:0] vpos = {2{24'h40_5860}};
   logic [1:0][1:0][7:0] vneg = {2{16'h0850}};
   logic [1:0][3:0] tab = {4'h7, 4'h3};
   logic [7:0]  ie_t [4] = '{8'h80, 8'h80, 8'h40, 8'h40};
   logic [7:0]  lv_t [4] = '{8'h60, 8'h30, 8'h60, 8'h30};
   logic [3:0]  fl_t = 4'h9;
   logic [31:0] expq [$];
   cmpdc_pkg::cmpdc_analog_s [1:0] actl;
   int          fail_count = 0, n_checks = 0, seed = 88524, cyc = 0, hi;

   cmpdc_top u_cmpdc_top (.core_clk_in(clk), .rstn_in(rstn), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
      .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
      .hresp_out(hresp), .raw_decision_in(raw), .analog_ctrl_out(actl),
      .timer_clk_in(tclk), .timer_result_out(tres), .pin_result_out(pres),
      .pin_override_out(povr), .port_level_in(plvl), .analog_sel_in(asel),
      .cmp_irq_flag_out(irq));
   cmpdc_partner u_cmpdc_partner (.core_clk_in(clk), .ctrl_in(actl), .vpos_in(vpos),
      .vneg_in(vneg), .raw_out(raw), .tclk_run_in(trun), .tclk_out(tclk));

   initial begin
      forever #5 clk = ~clk;
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      htrans <= 2'h2;
      haddr  <= {24'h00_0000, a};
      hwrite <= w;
      do @(posedge clk); while (!hrdy);
      htrans <= 2'h0;
      hwdata <= d;
      rd_ph  <= !w;
      do @(posedge clk); while (!hrdy);
      rd_ph  <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      expq.push_back(exp);
      bus(1'b0, a, 32'h0000_0000);
   endtask

   // read data is sampled mid data phase, clear of the launching edge
   always @(negedge clk) begin
      if (rd_ph && hrdy && expq.size() > 0)
         chk(hrdata, expq.pop_front());
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         fail_count++;
         summarize();
      end
   end

   task automatic look(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      rd(cmpdc_pkg::OFF_C1_CTRL_A, 32'h0000_0004);
      rd(cmpdc_pkg::OFF_MIRROR, 32'h0000_0000);
      rd(8'h1C, 32'h0000_0000);
      chk(32'(actl[1]), 32'h0000_0010);
      bus(1'b1, cmpdc_pkg::OFF_C1_CTRL_B, 32'h0000_00FF);
      rd(cmpdc_pkg::OFF_C1_CTRL_B, 32'h0000_00F1);
      bus(1'b1, cmpdc_pkg::OFF_C1_CTRL_A, 32'h0000_0082);
      for (int n = 0; n < 2; n++) begin
         for (int p = 0; p < 4; p++) begin
            bus(1'b1, cmpdc_pkg::OFF_C1_CTRL_B, 32'(p * 16 + n));
            look(12);
            chk(32'(actl[0]), 32'(40 + p * 2 + n));
            rd(cmpdc_pkg::OFF_C1_CTRL_A, 32'h0000_0082 | 32'(tab[n][p]) << 6);
            rd(cmpdc_pkg::OFF_MIRROR, 32'(tab[n][p]));
         end
      end
      for (int k = 0; k < 2; k++) begin
         bus(1'b1, cmpdc_pkg::OFF_C2_CTRL_A, 32'(8'h90 ^ k << 4));
         look(12);
         chk(32'({irq[1], tres[1], pres[1]}), 32'(k * 3));
         rd(cmpdc_pkg::OFF_C2_CTRL_A, 32'(8'h90 ^ k * 8'h50));
         rd(cmpdc_pkg::OFF_MIRROR, 32'(k * 2));
      end
      vpos[0][0] <= 8'h30;
      bus(1'b1, cmpdc_pkg::OFF_C1_CTRL_B, 32'h0000_0000);
      for (int k = 0; k < 4; k++) begin
         repeat (12) @(posedge clk);
         bus(1'b1, cmpdc_pkg::OFF_IRQ_FLAGS, 32'h0000_0003);
         bus(1'b1, cmpdc_pkg::OFF_C1_CTRL_B, 32'(ie_t[k]));
         vpos[0][0] <= lv_t[k];
         look(12);
         chk(32'(irq[0]), 32'(fl_t[k]));
      end
      bus(1'b1, cmpdc_pkg::OFF_C1_CTRL_A, 32'h0000_00A0);
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         vpos[0][0] <= lv_t[k];
         if (k == 2)
            bus(1'b1, cmpdc_pkg::OFF_C1_CTRL_A, 32'h0000_0020);
         look(3);
         chk(32'({povr[0], pres[0]}), 32'(3 - k + k / 2));
      end
      bus(1'b1, cmpdc_pkg::OFF_C1_CTRL_A, 32'h0000_00A1);
      look(20);
      chk(32'(pres[0]), 32'h0000_0000);
      trun <= 1'b1;
      look(20);
      chk(32'({tres[0], pres[0]}), 32'h0000_0003);
      trun <= 1'b0;
      for (int f = 0; f < 2; f++) begin
         bus(1'b1, cmpdc_pkg::OFF_C1_CTRL_A, 32'(8'hA0 | f << 3));
         vpos[0][0] <= 8'h30;
         repeat (12) @(posedge clk);
         vpos[0][0] <= 8'h60;
         @(posedge clk);
         vpos[0][0] <= 8'h30;
         hi = 0;
         repeat (10) begin
            @(negedge clk);
            hi += pres[0];
         end
         chk(32'(hi), f ? 32'(cmpdc_pkg::FILT_CYCLES) : 32'h0000_0001);
      end
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         plvl <= 6'($random(seed));
         asel <= 6'($random(seed));
         @(posedge clk);
         rd(cmpdc_pkg::OFF_PORT_DATA, {26'h000_0000, plvl & ~asel});
      end
      look(2);
      summarize();
   end
endmodule
